/* apl_latch_checker.sv */
// Port assertions for the position latch.
`timescale 1ns/10ps
module apl_latch_checker (
    input wire logic        pclk,                 // Clock.
    input wire logic        presetn,              // Reset.
    input wire logic        psel,                 // Select.
    input wire logic        penable,              // Access.
    input wire logic        pwrite,               // Write.
    input wire logic [11:0] paddr,                // Address.
    input wire logic [31:0] pwdata,               // Data.
    input wire logic [15:0] gp_inputs_n,          // Inputs.
    input wire logic [7:0]  index_pulse,          // Index.
    input wire logic [7:0]  capture_pending_flag, // Armed.
    input wire logic        irq                   // Interrupt.
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // An arm write is taken at the access edge.
    wire arm_wr = psel && penable && pwrite && paddr == 12'h000;
    chk_arm_sets: assert property (arm_wr |=>
        (capture_pending_flag & $past(pwdata[7:0])) == $past(pwdata[7:0])) else $error("no arm");
    chk_no_rearm: assert property ((capture_pending_flag & ~$past(capture_pending_flag))
        != 8'h00 |-> $past(arm_wr)) else $error("armed itself");
    chk_capture_first: assert property ($fell(gp_inputs_n[0]) && capture_pending_flag[0]
        |-> ##[2:3] !capture_pending_flag[0]) else $error("axis 0 late");
    chk_map_upper: assert property ($fell(gp_inputs_n[8]) && capture_pending_flag[4]
        |-> ##[2:3] !capture_pending_flag[4]) else $error("axis 4 late");
    chk_index_cap: assert property ($rose(index_pulse[1]) && capture_pending_flag[1]
        |-> ##[2:3] !capture_pending_flag[1]) else $error("index late");
    // Six quiet cycles cover the two sync stages, so a fall here has no cause.
    chk_axis_quiet: assert property ((gp_inputs_n[1] && !index_pulse[1])[*6]
        |-> !$fell(capture_pending_flag[1])) else $error("axis 1 fell");
    cover property ($fell(capture_pending_flag[0]));
    cover property (arm_wr);
    cover property ($rose(irq));
endmodule // apl_latch_checker
bind apl_position_latch apl_latch_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .irq(irq),
    .gp_inputs_n(gp_inputs_n), .index_pulse(index_pulse),
    .capture_pending_flag(capture_pending_flag));

/* apl_position_latch.v */
// Eight-axis position capture unit with APB registers and a capture interrupt.
//
// Functional notes
// - Armed axis captures within 25 us.
// - Inputs 1-4 and 9-12 trigger axes 1-8.
// - Arm per axis, selecting main or auxiliary.
// - Pending flag reads 1 until captured.
// - Frozen position held and readable.
// - One capture per arm; re-arm required.
//
// Register map, one 32-bit word each, byte addresses:
//   0x00 arm: write ones in bits 7:0 to arm axes, bits 15:8 pick
//        the auxiliary encoder for those axes; reads the armed bits.
//   0x04 source select: one bit per axis, 1 picks the auxiliary encoder.
//   0x08 pending: reads 1 for each axis armed and not yet triggered.
//   0x0c capture status: sticky, one bit per axis, write one to clear.
//   0x10 capture mask: a set bit lets that axis raise the interrupt.
//   0x14 inputs: synchronised levels of general inputs 1..16, 1 = low pin.
//   0x40 + 4*k: position frozen by the last capture of axis k.
// Writing zero to the arm word never disarms an axis; only a capture does.
// An access to any other address answers with an error and changes nothing.
//
// Capture latency is two synchroniser edges plus one edge stage, so the
// held word is written on the third clock edge after the pin falls. At the
// 10 MHz clock that is 300 ns, far inside the 25 us bound.
//
// Interrupt: each capture sets its status bit; the level output is high
// while any status bit is set whose mask bit is set too. A capture and a
// write-one clear in the same cycle leave the bit set.
//
// Limitations: a pin that is already low when an axis is armed does not
// capture until it rises and falls again, and a pulse shorter than one
// clock period may slip past the synchroniser unseen.
`timescale 1ns/10ps
`include "apl_regs.vh"
module apl_position_latch (
    input  wire         pclk,          // Bus and servo clock, 10 MHz.
    input  wire         presetn,       // Asynchronous reset, active low.
    input  wire         psel,          // APB select.
    input  wire         penable,       // APB access phase.
    input  wire         pwrite,        // APB write direction.
    input  wire [11:0]  paddr,         // APB byte address.
    input  wire [31:0]  pwdata,        // APB write data.
    output wire [31:0]  prdata,        // APB read data, registered.
    output wire         pready,        // APB ready, always high.
    output wire         pslverr,       // APB error on unmapped address.
    input  wire [15:0]  gp_inputs_n,   // General inputs 1..16, active low.
    input  wire [255:0] main_pos,      // Main encoder positions, axis 0 in low word.
    input  wire [255:0] aux_pos,       // Auxiliary encoder positions, axis 0 in low word.
    input  wire [7:0]   index_pulse,   // Encoder index pulses, one per axis.
    output wire [7:0]   capture_pending_flag, // High while an axis is armed.
    output wire         irq            // Level interrupt on an unmasked capture.
);
    localparam NA = `APL_NAXES;
    localparam PW = `APL_POS_W;

    // Two-stage synchronisers for the pins, then one stage of edge history.
    reg  [15:0]   in_s1_ff, in_s2_ff;
    reg  [7:0]    idx_s1_ff, idx_s2_ff;
    reg  [7:0]    trig_prev_ff, idx_prev_ff;
    // Per-axis arm, source and interrupt state.
    reg  [7:0]    armed_ff;
    reg  [7:0]    srcsel_ff;
    reg  [7:0]    int_stat_ff;
    reg  [7:0]    int_mask_ff;
    reg  [31:0]   prdata_ff;
    // Frozen positions, one word per axis.
    reg  [PW-1:0] held_ff [0:NA-1];
    integer       ax;
    wire [7:0]    trig_lvl;
    wire [7:0]    capture;
    // Bus decodes: writes land at the access edge, reads are fetched at setup.
    wire          wr_en     = psel & penable & pwrite;
    wire          rd_setup  = psel & ~penable & ~pwrite;
    wire          wr_arm    = wr_en & (paddr == `APL_OFF_ARM);
    wire          wr_srcsel = wr_en & (paddr == `APL_OFF_SRCSEL);
    wire          wr_stat   = wr_en & (paddr == `APL_OFF_INT_STAT);
    wire          wr_mask   = wr_en & (paddr == `APL_OFF_INT_MASK);

    // Map an axis number to the bit of its trigger input.
    // Axes 4 to 7 skip inputs 5 to 8, which stay free for other uses.
    function [3:0] axis_input;
        input integer a;
        begin
            axis_input = (a < 4) ? a[3:0] : a[3:0] + 4'h4;
        end
    endfunction

    // Decode a register address to a valid flag.
    function addr_ok;
        input [11:0] a;
        begin
            addr_ok = (a == `APL_OFF_ARM) || (a == `APL_OFF_SRCSEL) ||
                      (a == `APL_OFF_PENDING) || (a == `APL_OFF_INT_STAT) ||
                      (a == `APL_OFF_INT_MASK) || (a == `APL_OFF_INPUTS) ||
                      ((a >= `APL_OFF_POS_BASE) && (a < `APL_OFF_POS_BASE + 12'h020) &&
                       (a[1:0] == 2'b00));
        end
    endfunction

    // Pins come from outside the clock domain, so two flops precede any logic.
    // They reset to the idle levels, so a release of reset makes no false edge.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_s1_ff  <= 16'hffff;
            in_s2_ff  <= 16'hffff;
            idx_s1_ff <= 8'h00;
            idx_s2_ff <= 8'h00;
        end else begin
            in_s1_ff  <= gp_inputs_n;
            in_s2_ff  <= in_s1_ff;
            idx_s1_ff <= index_pulse;
            idx_s2_ff <= idx_s1_ff;
        end
    end

    // Per-axis trigger slices; each sees only its own pin and index line.
    genvar g;
    generate
        for (g = 0; g < NA; g = g + 1) begin : g_axis
            assign trig_lvl[g] = ~in_s2_ff[axis_input(g)];
            // Only a high-to-low edge or a rising index counts as an event.
            assign capture[g] = armed_ff[g] &
                                ((trig_lvl[g] & ~trig_prev_ff[g]) |
                                 (idx_s2_ff[g] & ~idx_prev_ff[g]));
        end
    endgenerate

    // The held words share one process so the array has a single driver; each
    // word still moves only on its own axis's capture. A source change written
    // in the capture cycle applies to the next capture, not to this one.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (ax = 0; ax < NA; ax = ax + 1) begin
                held_ff[ax] <= {PW{1'b0}};
            end
        end else begin
            // Every axis is looked at on every edge, so none waits for another.
            for (ax = 0; ax < NA; ax = ax + 1) begin
                if (capture[ax]) begin
                    held_ff[ax] <= srcsel_ff[ax] ? aux_pos[ax*PW +: PW]
                                                 : main_pos[ax*PW +: PW];
                end
            end
        end
    end

    // Arm, source select, edge history and interrupt state.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_ff <= 8'h00;
            idx_prev_ff  <= 8'h00;
            armed_ff     <= 8'h00;
            srcsel_ff    <= `APL_RST_SRCSEL;
            int_stat_ff  <= 8'h00;
            int_mask_ff  <= `APL_RST_MASK;
        end else begin
            // Edge history runs whether or not the axis is armed.
            trig_prev_ff <= trig_lvl;
            idx_prev_ff  <= idx_s2_ff;
            // Arming a bit sets it; a capture clears only that bit, single-shot.
            // An arm write in the capture cycle wins, since software asked last.
            if (wr_arm) begin
                armed_ff <= (armed_ff & ~capture) | pwdata[7:0];
            end else begin
                armed_ff <= armed_ff & ~capture;
            end
            // Source choice is latched per axis with the arm write.
            if (wr_arm) begin
                srcsel_ff <= (srcsel_ff & ~pwdata[7:0]) | (pwdata[7:0] & pwdata[15:8]);
            end else if (wr_srcsel) begin
                srcsel_ff <= pwdata[7:0];
            end
            // Set wins over a write-one clear in the same cycle.
            if (wr_stat) begin
                int_stat_ff <= (int_stat_ff & ~pwdata[7:0]) | capture;
            end else begin
                int_stat_ff <= int_stat_ff | capture;
            end
            // The mask only gates the interrupt; status bits still collect.
            if (wr_mask) begin
                int_mask_ff <= pwdata[7:0];
            end
        end
    end

    // Read data is registered at the setup edge and stands through the access
    // cycle, so pready can stay high with no wait state.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (rd_setup) begin
            case (paddr)
                `APL_OFF_ARM:      prdata_ff <= {24'h000000, armed_ff};
                `APL_OFF_SRCSEL:   prdata_ff <= {24'h000000, srcsel_ff};
                `APL_OFF_PENDING:  prdata_ff <= {24'h000000, armed_ff};
                `APL_OFF_INT_STAT: prdata_ff <= {24'h000000, int_stat_ff};
                `APL_OFF_INT_MASK: prdata_ff <= {24'h000000, int_mask_ff};
                `APL_OFF_INPUTS:   prdata_ff <= {16'h0000, ~in_s2_ff};
                default: begin
                    // Held words sit at 0x40 + 4*k; every other address reads zero.
                    if (addr_ok(paddr)) begin
                        prdata_ff <= held_ff[paddr[4:2]];
                    end else begin
                        prdata_ff <= 32'h00000000;
                    end
                end
            endcase
        end
    end

    // Bus answers: zero wait states, error only on an unmapped access.
    // The interrupt is a plain level of registered bits, so it carries no glitch.
    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok(paddr);
    assign capture_pending_flag = armed_ff;
    assign irq     = |(int_stat_ff & int_mask_ff);

endmodule // apl_position_latch

/* apl_position_latch_tb_top.sv */
// Self-checking bench for the position latch.
`timescale 1ns/10ps
module apl_position_latch_tb_top;
    logic         pclk, presetn, psel, penable, pwrite, fire, pready, pslverr, irq, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd, base, ex;
    logic [255:0] main_pos, aux_pos;
    logic [15:0]  gp_inputs_n;
    logic [7:0]   index_pulse, capture_pending_flag;
    logic [3:0]   pin;
    integer       mismatches = 0, cmp_count = 0, k, j;
    apl_position_latch uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gp_inputs_n(gp_inputs_n), .main_pos(main_pos), .aux_pos(aux_pos),
        .index_pulse(index_pulse), .capture_pending_flag(capture_pending_flag), .irq(irq));
    apl_sensor_model sensor (.pclk(pclk), .fire(fire), .pin(pin), .gp_inputs_n(gp_inputs_n));
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Request is held until pready is seen high; release is left to idle.
    task xfer(input [11:0] a, input w, input [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
    endtask
    task rdc(input [11:0] a, input [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task idle(input integer n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
    // Moves every encoder so a held value can be told from a live one.
    task setpos(input [31:0] b);
        base = b;
        for (k = 0; k < 8; k = k + 1) begin
            main_pos[k*32 +: 32] <= b + 32'(k);
            aux_pos[k*32 +: 32] <= b + 32'h100 + 32'(k);
        end
    endtask
    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #2000000;
        mismatches = mismatches + 1;
        wrap_up;
    end
    initial begin
        {presetn, psel, penable, pwrite, fire, paddr, pwdata, pin, index_pulse} = '0;
        setpos(32'h10);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(12'h008, 32'h0);
        chk({31'h0, err}, 32'h0);
        rdc(12'h0fc, 32'h0);
        chk({31'h0, err}, 32'h1);
        xfer(12'h010, 1'b1, 32'hff);
        xfer(12'h000, 1'b1, 32'hf0ff);
        rdc(12'h008, 32'hff);
        idle(1);
        for (j = 0; j < 8; j = j + 1) begin
            pin <= (j < 4) ? 4'(j) : 4'(j + 4);
            fire <= 1'b1;
            @(posedge pclk);
            fire <= 1'b0;
            ex = base + 32'(j) + ((j < 4) ? 32'h0 : 32'h100);
            idle(6);
            setpos(base + 32'h1000);
            rdc(12'h040 + 12'(4 * j), ex);
            rdc(12'h008, (32'hff << (j + 1)) & 32'hff);
            chk({24'h0, capture_pending_flag}, (32'hff << (j + 1)) & 32'hff);
            idle(1);
        end
        chk({31'h0, irq}, 32'h1);
        rdc(12'h00c, 32'hff);
        $display("test capture done");
        pin <= 4'h0;
        fire <= 1'b1;
        idle(1);
        fire <= 1'b0;
        idle(2);
        rdc(12'h014, 32'h1);
        idle(3);
        rdc(12'h040, 32'h10);
        xfer(12'h000, 1'b1, 32'h2);
        idle(1);
        index_pulse <= 8'h02;
        ex = base + 32'h1;
        @(posedge pclk);
        index_pulse <= 8'h00;
        idle(6);
        setpos(base + 32'h1000);
        rdc(12'h044, ex);
        xfer(12'h004, 1'b1, 32'h5a);
        rdc(12'h004, 32'h5a);
        xfer(12'h010, 1'b1, 32'h0);
        idle(1);
        chk({31'h0, irq}, 32'h0);
        xfer(12'h00c, 1'b1, 32'hff);
        rdc(12'h00c, 32'h0);
        idle(1);
        $display("test rearm done");
        wrap_up;
    end
endmodule // apl_position_latch_tb_top

/* apl_regs.vh */
// Register offsets, reset values and timing counts of the position latch.
`ifndef APL_REGS_VH
`define APL_REGS_VH
`define APL_NAXES          8
`define APL_POS_W          32
`define APL_CLK_HZ         10000000
`define APL_CAPTURE_US     25
`define APL_CAPTURE_CYC    ((`APL_CAPTURE_US * `APL_CLK_HZ) / 1000000)
`define APL_OFF_ARM        12'h000
`define APL_OFF_SRCSEL     12'h004
`define APL_OFF_PENDING    12'h008
`define APL_OFF_INT_STAT   12'h00c
`define APL_OFF_INT_MASK   12'h010
`define APL_OFF_INPUTS     12'h014
`define APL_OFF_POS_BASE   12'h040
`define APL_RST_SRCSEL     8'h00
`define APL_RST_MASK       8'h00
`endif

/* apl_sensor_model.sv */
// Switch model that pulls one general input low.
`timescale 1ns/10ps
module apl_sensor_model (
    input  wire logic        pclk,       // Clock.
    input  wire logic        fire,       // Start a low pulse.
    input  wire logic [3:0]  pin,        // Input number less one.
    output wire logic [15:0] gp_inputs_n // Lines with pull-ups.
);
    logic [3:0] cnt_ff = 4'h0;
    // Low time counter; idle lines rest at the pull-up level.
    always @(posedge pclk) begin
        if (fire) cnt_ff <= 4'h3;
        else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
    end
    // Only a clean high-to-low step is offered.
    assign gp_inputs_n = (cnt_ff != 4'h0) ? ~(16'h0001 << pin) : 16'hffff;
endmodule // apl_sensor_model
